// ### core/dcff_pkg.sv
// Constants, register map and mode type of the dual-clock FIFO flag block
package dcff_pkg;
    localparam int DATA_W = 72;                      // FIFO word width
    localparam int ADDR_W = 9;                       // Memory address width
    localparam int OFF_W  = 9;                       // Offset register width, log2 of depth
    localparam int LVL_W  = 10;                      // Fill level width
    localparam int INT_W  = 4;                       // Interrupt source count
    localparam logic [LVL_W-1:0] DEPTH_STD = 10'h200;   // 512 words in standard mode
    localparam logic [LVL_W-1:0] DEPTH_FT  = 10'h201;   // 513 words in fall-through mode
    localparam logic [OFF_W-1:0] PAE_OFF_RST = 9'h07f; // Almost-empty offset after reset
    localparam logic [OFF_W-1:0] PAF_OFF_RST = 9'h07f; // Almost-full offset after reset
    localparam logic [1:0] RT_SETUP = 2'h2;          // Read cycles of retransmit setup
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_PAE_OFF  = 8'h08;
    localparam logic [7:0] ADDR_PAF_OFF  = 8'h0c;
    localparam logic [7:0] ADDR_INT_STAT = 8'h10;
    localparam logic [7:0] ADDR_INT_MASK = 8'h14;
    // Control register bits
    localparam int CTRL_MRST = 0;                    // Master reset, self clearing
    localparam int CTRL_PRST = 1;                    // Partial reset, self clearing
    localparam int CTRL_RT   = 2;                    // Retransmit request, self clearing
    localparam int CTRL_FT   = 3;                    // Fall-through mode strap
    localparam int CTRL_RTM  = 4;                    // Retransmit mode strap
    localparam int CTRL_FTM  = 5;                    // Flag timing mode strap
    // Status and interrupt bits
    localparam int ST_FULL  = 0;
    localparam int ST_EMPTY = 1;
    localparam int ST_AFULL = 2;
    localparam int ST_AEMPT = 3;
    localparam int ST_LVL   = 16;                    // Level field low bit
    typedef struct packed {
        logic fall_through_mode;                     // 1: fall-through, 0: standard
        logic retransmit_mode;                       // 1: normal, 0: zero latency
        logic flag_timing_mode;                      // 1: synchronous almost-full
    } dcff_mode_s;
endpackage

// ### core/dcff_mem.sv
// FIFO storage array with registered read data
`timescale 1ns/1ps
module dcff_mem import dcff_pkg::*; (
    input  wire logic              clk,    // System clock
    input  wire logic              we,     // Write strobe
    input  wire logic [ADDR_W-1:0] waddr,  // Write address
    input  wire logic [DATA_W-1:0] wdata,  // Write data
    input  wire logic              re,     // Read strobe
    input  wire logic [ADDR_W-1:0] raddr,  // Read address
    output logic      [DATA_W-1:0] rdata   // Registered read data
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // Write port
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read port, data valid the cycle after the strobe
    always_ff @(posedge clk) begin
        if (re) begin
            rdata <= mem[raddr];
        end
    end
endmodule

// ### core/dcff_top.sv
// Dual-clock FIFO flags, resets and retransmit with an AHB-Lite register slave
//
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
module dcff_top import dcff_pkg::*; (
    input  wire logic              hclk,                // System clock
    input  wire logic              hresetn,             // Async reset, active low
    input  wire logic              hsel,                // Slave select
    input  wire logic [31:0]       haddr,               // Byte address
    input  wire logic [1:0]        htrans,              // Transfer type
    input  wire logic              hwrite,              // Write transfer
    input  wire logic [2:0]        hsize,               // Transfer size, word only
    input  wire logic [31:0]       hwdata,              // Write data
    input  wire logic              hready,              // Bus ready
    output logic                   hreadyout,           // Slave ready
    output logic                   hresp,               // Always OKAY
    output logic      [31:0]       hrdata,              // Read data
    input  wire logic              wr_tick,             // Write clock enable
    input  wire logic              rd_tick,             // Read clock enable
    input  wire logic              wr_en_n,             // Write enable
    input  wire logic [DATA_W-1:0] wdata,               // Write data
    input  wire logic              rd_en_n,             // Read enable
    input  wire logic              read_chip_select_n,  // Output chip select
    input  wire logic              out_enable_n,        // Output enable
    input  wire logic              offset_load_n,       // Offset access select
    output logic      [DATA_W-1:0] q_data,              // Output data
    output logic                   q_oe,                // Output data driven
    output logic                   full_flag_n,         // Standard full flag
    output logic                   input_ready_n,       // Fall-through input ready
    output logic                   empty_flag_n,        // Standard empty flag
    output logic                   output_ready_n,      // Fall-through output ready
    output logic                   almost_full_flag_n,  // Almost-full flag
    output logic                   almost_empty_flag_n, // Almost-empty flag
    output logic                   irq                  // Interrupt, active high level
);
    dcff_mode_s        mode_reg, mode_now;
    logic [ADDR_W-1:0] wr_ptr_reg, rd_ptr_reg, raddr;
    logic [LVL_W-1:0]  mem_cnt_reg, total;
    logic [OFF_W-1:0]  pae_off_reg, paf_off_reg;
    logic [INT_W-1:0]  int_stat_reg, int_mask_reg, cond, cond_d_reg;
    logic [1:0]        setup_reg;
    logic [7:0]        ap_addr_reg;
    logic [31:0]       rd_val;
    logic [DATA_W-1:0] mem_rdata;
    logic out_valid_reg, pend_reg, sel_paf_reg, rst_hold_reg, ap_wr_reg, ap_rd_reg;
    logic ap, wr_ctrl, mrst, prst, any_rst, rt_req, rt_zl, ft, full_c, empty_c;
    logic paf_c, pae_c, wr_fire, rd_req, off_rd, rd_fire, ft_take, fetch, ov_next;

    // Bus decode; writes act in the data phase
    assign ap      = hsel && hready && htrans[1];
    assign wr_ctrl = ap_wr_reg && (ap_addr_reg == ADDR_CTRL);
    assign mrst    = wr_ctrl && hwdata[CTRL_MRST];
    assign prst    = wr_ctrl && hwdata[CTRL_PRST];
    assign any_rst = mrst || prst;
    assign rt_req  = wr_ctrl && hwdata[CTRL_RT] && !any_rst;
    assign rt_zl   = rt_req && !mode_reg.retransmit_mode && (wr_ptr_reg != '0);
    assign ft      = mode_reg.fall_through_mode;
    // Straps are taken from the same write that starts master reset
    assign mode_now = mrst ? '{fall_through_mode: hwdata[CTRL_FT],
                              retransmit_mode:   hwdata[CTRL_RTM],
                              flag_timing_mode:  hwdata[CTRL_FTM]} : mode_reg;

    // Fill level and flag conditions; the output register adds one word
    assign total   = mem_cnt_reg + LVL_W'(out_valid_reg) + LVL_W'(pend_reg);
    assign full_c  = ft ? (total >= DEPTH_FT) : (mem_cnt_reg >= DEPTH_STD);
    assign empty_c = (total == '0);
    assign paf_c   = total >= ((ft ? DEPTH_FT : DEPTH_STD) - LVL_W'(paf_off_reg));
    assign pae_c   = total <= LVL_W'(pae_off_reg);
    assign cond    = {pae_c, paf_c, empty_c, full_c};

    // Port strobes
    assign wr_fire = wr_tick && !wr_en_n && !full_c && !any_rst;
    assign rd_req  = rd_tick && !rd_en_n && !any_rst && !rt_req;
    assign off_rd  = rd_req && !offset_load_n;
    assign rd_fire = rd_req && offset_load_n && !ft && empty_flag_n
                     && (setup_reg == '0) && (mem_cnt_reg != '0);
    assign ft_take = rd_req && offset_load_n && ft && out_valid_reg;
    assign fetch   = ft ? ((!out_valid_reg || ft_take) && !pend_reg && (setup_reg == '0)
                           && (mem_cnt_reg != '0) && !any_rst && !rt_req) : rd_fire;
    assign raddr   = rt_zl ? '0 : rd_ptr_reg;
    assign ov_next = !any_rst && !rt_req && (pend_reg || (out_valid_reg && !ft_take));

    dcff_mem u_mem (
        .clk   (hclk),
        .we    (wr_fire),
        .waddr (wr_ptr_reg),
        .wdata (wdata),
        .re    (fetch || rt_zl),
        .raddr (raddr),
        .rdata (mem_rdata)
    );

    // Mode straps and offsets
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_reg    <= '0;
            pae_off_reg <= PAE_OFF_RST;
            paf_off_reg <= PAF_OFF_RST;
        end else if (mrst) begin
            mode_reg    <= mode_now;
            pae_off_reg <= PAE_OFF_RST;
            paf_off_reg <= PAF_OFF_RST;
        end else if (ap_wr_reg && ap_addr_reg == ADDR_PAE_OFF) begin
            pae_off_reg <= hwdata[OFF_W-1:0];
        end else if (ap_wr_reg && ap_addr_reg == ADDR_PAF_OFF) begin
            paf_off_reg <= hwdata[OFF_W-1:0];
        end
    end

    // Write pointer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr_reg <= '0;
        end else if (any_rst) begin
            wr_ptr_reg <= '0;
        end else if (wr_fire) begin
            wr_ptr_reg <= wr_ptr_reg + ADDR_W'(1);
        end
    end

    // Read pointer, level, output register state and retransmit setup
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_ptr_reg    <= '0;
            mem_cnt_reg   <= '0;
            out_valid_reg <= 1'b0;
            pend_reg      <= 1'b0;
            setup_reg     <= '0;
        end else if (any_rst) begin
            rd_ptr_reg    <= '0;
            mem_cnt_reg   <= '0;
            out_valid_reg <= 1'b0;
            pend_reg      <= 1'b0;
            setup_reg     <= '0;
        end else if (rt_req) begin
            // Rewind to address 0; level rebuilt from the write pointer, which wraps to 0 on the 512th write
            rd_ptr_reg    <= rt_zl ? ADDR_W'(1) : '0;
            mem_cnt_reg   <= LVL_W'(wr_ptr_reg) + LVL_W'(wr_fire) - LVL_W'(rt_zl);
            out_valid_reg <= 1'b0;
            pend_reg      <= rt_zl;
            setup_reg     <= mode_reg.retransmit_mode ? RT_SETUP : '0;
        end else begin
            rd_ptr_reg    <= rd_ptr_reg + ADDR_W'(fetch);
            mem_cnt_reg   <= mem_cnt_reg + LVL_W'(wr_fire) - LVL_W'(fetch);
            out_valid_reg <= ft && ov_next;
            pend_reg      <= fetch;
            if (rd_tick && setup_reg != '0) begin
                setup_reg <= setup_reg - 2'h1;
            end
        end
    end

    // Output data: fetched word or offset readback
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q_data      <= '0;
            sel_paf_reg <= 1'b0;
        end else begin
            if (off_rd) begin
                q_data      <= DATA_W'(sel_paf_reg ? paf_off_reg : pae_off_reg);
                sel_paf_reg <= !sel_paf_reg;
            end else begin
                if (pend_reg) begin
                    q_data <= mem_rdata;
                end
                if (offset_load_n) begin
                    sel_paf_reg <= 1'b0;
                end
            end
        end
    end

    // Output tristate; chip select ignored through reset up to the next read tick
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_hold_reg <= 1'b1;
            q_oe         <= 1'b0;
        end else begin
            rst_hold_reg <= any_rst || (rst_hold_reg && !rd_tick);
            q_oe <= !out_enable_n && (any_rst || rst_hold_reg || !read_chip_select_n);
        end
    end

    // Full and input-ready on write ticks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            full_flag_n   <= 1'b1;
            input_ready_n <= 1'b1;
        end else if (any_rst) begin
            full_flag_n   <= 1'b1;
            input_ready_n <= !mode_now.fall_through_mode;
        end else if (wr_tick) begin
            full_flag_n   <= ft || !full_c;
            input_ready_n <= !ft || full_c;
        end
    end

    // Empty and output-ready on read ticks and in the cycle after each fetch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            empty_flag_n   <= 1'b0;
            output_ready_n <= 1'b1;
        end else if (any_rst || rt_req) begin
            empty_flag_n   <= mode_now.fall_through_mode;
            output_ready_n <= 1'b1;
        end else if (rd_tick || pend_reg) begin
            empty_flag_n   <= ft || (mem_cnt_reg != '0 && setup_reg == '0);
            output_ready_n <= !ft || !ov_next;
        end
    end

    // Almost-full and almost-empty, synchronous or split over the two ticks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            almost_full_flag_n  <= 1'b1;
            almost_empty_flag_n <= 1'b0;
        end else if (any_rst) begin
            almost_full_flag_n  <= 1'b1;
            almost_empty_flag_n <= 1'b0;
        end else if (mode_reg.flag_timing_mode) begin
            if (wr_tick) begin
                almost_full_flag_n <= !paf_c;
            end
            if (rd_tick) begin
                almost_empty_flag_n <= !pae_c;
            end
        end else begin
            if (wr_tick && paf_c) begin
                almost_full_flag_n <= 1'b0;
            end else if (rd_tick && !paf_c) begin
                almost_full_flag_n <= 1'b1;
            end
            if (rd_tick && pae_c) begin
                almost_empty_flag_n <= 1'b0;
            end else if (wr_tick && !pae_c) begin
                almost_empty_flag_n <= 1'b1;
            end
        end
    end

    // Sticky interrupt status; a new event wins over the read clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cond_d_reg   <= '0;
            int_stat_reg <= '0;
            int_mask_reg <= '0;
            irq          <= 1'b0;
        end else begin
            cond_d_reg <= cond;
            if (ap_rd_reg && ap_addr_reg == ADDR_INT_STAT) begin
                int_stat_reg <= cond & ~cond_d_reg;
            end else begin
                int_stat_reg <= int_stat_reg | (cond & ~cond_d_reg);
            end
            if (ap_wr_reg && ap_addr_reg == ADDR_INT_MASK) begin
                int_mask_reg <= hwdata[INT_W-1:0];
            end
            irq <= |(int_stat_reg & int_mask_reg);
        end
    end

    // Register read mux; unmapped addresses read zero
    always_comb begin
        rd_val = '0;
        case (ap_addr_reg)
            ADDR_CTRL: begin
                rd_val[CTRL_FT]  = mode_reg.fall_through_mode;
                rd_val[CTRL_RTM] = mode_reg.retransmit_mode;
                rd_val[CTRL_FTM] = mode_reg.flag_timing_mode;
            end
            ADDR_STATUS: begin
                rd_val[INT_W-1:0]          = cond;
                rd_val[ST_LVL +: LVL_W]    = total;
            end
            ADDR_PAE_OFF:  rd_val[OFF_W-1:0] = pae_off_reg;
            ADDR_PAF_OFF:  rd_val[OFF_W-1:0] = paf_off_reg;
            ADDR_INT_STAT: rd_val[INT_W-1:0] = int_stat_reg;
            ADDR_INT_MASK: rd_val[INT_W-1:0] = int_mask_reg;
            default:       rd_val = '0;
        endcase
    end

    // AHB-Lite slave: writes zero wait, reads one wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_reg   <= 1'b0;
            ap_rd_reg   <= 1'b0;
            ap_addr_reg <= '0;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            hrdata      <= '0;
        end else begin
            ap_wr_reg <= ap && hwrite;
            ap_rd_reg <= ap && !hwrite;
            if (ap) begin
                ap_addr_reg <= {haddr[7:2], 2'b00};
            end
            hreadyout <= !(ap && !hwrite);
            hresp     <= 1'b0;
            if (ap_rd_reg) begin
                hrdata <= rd_val;
            end
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    oe_during_reset_a: assert property (any_rst |=> q_oe == !$past(out_enable_n))
        else $error("output enable not sole control in reset");
    full_release_a: assert property (wr_tick && !ft && !full_c && !any_rst |=> full_flag_n)
        else $error("full flag not released");
    empty_release_a: assert property (rd_tick && !ft && !any_rst && !rt_req
        && mem_cnt_reg != '0 && setup_reg == '0 |=> empty_flag_n)
        else $error("empty flag not released");
    first_word_a: assert property (rd_fire |=> pend_reg ##1 q_data == $past(mem_rdata))
        else $error("read word not presented");
    ready_assert_a: assert property (wr_tick && ft && !full_c && !any_rst |=> !input_ready_n)
        else $error("input ready not asserted");
    afull_sync_a: assert property (mode_reg.flag_timing_mode && !any_rst && !wr_tick
        |=> $stable(almost_full_flag_n))
        else $error("almost full moved without write tick");
    afull_release_a: assert property (mode_reg.flag_timing_mode && wr_tick
        && !paf_c && !any_rst |=> almost_full_flag_n)
        else $error("almost full not released");
    afull_async_a: assert property (!mode_reg.flag_timing_mode && wr_tick
        && paf_c && !any_rst |=> !almost_full_flag_n)
        else $error("async almost full not set");
    zero_latency_a: assert property (rt_zl |=> pend_reg ##1 (q_data == $past(mem_rdata)))
        else $error("zero latency retransmit not fetched");
    normal_setup_a: assert property (rt_req && mode_reg.retransmit_mode
        |=> setup_reg == RT_SETUP && !empty_flag_n == !ft)
        else $error("normal retransmit setup missing");
    depth_limit_a: assert property (ft && total == DEPTH_FT |-> !wr_fire)
        else $error("write past fall-through depth");
    offset_read_a: assert property (off_rd && sel_paf_reg
        |=> q_data[OFF_W-1:0] == $past(paf_off_reg))
        else $error("offset readback order wrong");
endmodule

// ### testbench/dcff_peer.sv
// Writer and reader logic that sits on the far side of the FIFO data ports
`timescale 1ns/1ps
module dcff_peer import dcff_pkg::*; (
    input  wire logic              hclk,     // System clock
    input  wire logic              hold,     // Stop both ticks
    input  wire logic              wr_go,    // Write one word each cycle
    input  wire logic              rd_go,    // Read one word each cycle
    output logic                   wr_tick,  // Write clock enable
    output logic                   rd_tick,  // Read clock enable
    output logic                   wr_en_n,  // Write enable
    output logic                   rd_en_n,  // Read enable
    output logic      [DATA_W-1:0] wdata,    // Write data
    output logic      [15:0]       wr_cnt    // Words offered so far
);
    // Quiet start
    initial begin
        wr_tick = 1'b0;
        rd_tick = 1'b0;
        wr_en_n = 1'b1;
        rd_en_n = 1'b1;
        wdata   = '0;
        wr_cnt  = 16'h0;
    end
    // Ticks stand still while held; each word carries its index
    always @(posedge hclk) begin
        wr_tick <= !hold;
        rd_tick <= !hold;
        wr_en_n <= !wr_go;
        rd_en_n <= !rd_go;
        if (wr_go) begin
            wdata  <= {56'h0, wr_cnt};
            wr_cnt <= wr_cnt + 16'h1;
        end else begin
            wdata <= ~wdata; // Released bus does not keep the last word
        end
    end
endmodule

// ### testbench/tb_dcff_top.sv
// Register, flag, retransmit and offset tests of the FIFO flag block
`timescale 1ns/1ps
module tb_dcff_top import dcff_pkg::*;;
    logic              hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [1:0]        htrans = 2'h0;
    logic [31:0]       haddr = 32'h0, hwdata = 32'h0, hrdata, rd_seen, r;
    logic              rdy_seen, hold = 1'b0, wr_go = 1'b0, rd_go = 1'b0;
    logic              cs_n = 1'b1, oe_n = 1'b0, load_n = 1'b1, q_oe;
    logic              wr_tick, rd_tick, wr_en_n, rd_en_n;
    logic [DATA_W-1:0] wdata, q_data;
    logic [15:0]       wr_cnt, base;
    logic [8:0]        fl;
    int                mismatches = 0, samples_checked = 0;
    always #10 hclk = ~hclk;
    // Bus values as they stand at the coming rising edge
    always @(negedge hclk) begin
        rdy_seen = hreadyout;
        rd_seen  = hrdata;
    end
    dcff_peer peer_u (.hclk(hclk), .hold(hold), .wr_go(wr_go), .rd_go(rd_go),
        .wr_tick(wr_tick), .rd_tick(rd_tick), .wr_en_n(wr_en_n), .rd_en_n(rd_en_n),
        .wdata(wdata), .wr_cnt(wr_cnt));
    dcff_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .wr_tick(wr_tick),
        .rd_tick(rd_tick), .wr_en_n(wr_en_n), .wdata(wdata), .rd_en_n(rd_en_n),
        .read_chip_select_n(cs_n), .out_enable_n(oe_n), .offset_load_n(load_n),
        .q_data(q_data), .q_oe(q_oe), .full_flag_n(fl[7]), .input_ready_n(fl[2]),
        .empty_flag_n(fl[1]), .output_ready_n(fl[3]), .almost_full_flag_n(fl[4]),
        .almost_empty_flag_n(fl[8]), .irq(fl[5]));
    assign fl[0] = hresp;
    assign fl[6] = q_oe;
    task automatic summarize();
        if (mismatches == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [71:0] exp, input logic [71:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", nm, exp, got);
            mismatches++;
        end
    endtask
    // One single transfer; waits on hready for both phases
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (rdy_seen !== 1'b1 && ++n < 50);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (rdy_seen !== 1'b1 && ++n < 50);
        r = rd_seen;
        if (n >= 50) mismatches++;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, {40'h0, exp}, {40'h0, r});
    endtask
    // Wait a bounded time for a flag to reach a level
    task automatic waitf(input int k, input logic v, input int lim, input string nm);
        int n;
        n = 0;
        do @(negedge hclk); while (fl[k] !== v && ++n < lim);
        chk(nm, {71'h0, v}, {71'h0, fl[k]});
        @(posedge hclk);
    endtask
    task automatic push(input int n);
        @(posedge hclk);
        wr_go <= 1'b1;
        repeat (n) @(posedge hclk);
        wr_go <= 1'b0;
    endtask
    // One read request, then the word or offset that it brings out
    task automatic pop(input logic [71:0] exp, input string nm);
        @(posedge hclk);
        rd_go <= 1'b1;
        @(posedge hclk);
        rd_go <= 1'b0;
        repeat (4) @(negedge hclk);
        chk(nm, exp, q_data);
        @(posedge hclk);
    endtask
    initial begin
        #200us;
        mismatches++;
        summarize();
    end
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(ADDR_CTRL, 32'h0, "ctrl");
        rchk(ADDR_PAE_OFF, 32'h7f, "pae_off");
        bus(1'b1, ADDR_PAF_OFF, 32'hffffffff);
        rchk(ADDR_PAF_OFF, 32'h1ff, "paf_off");
        rchk(8'h20, 32'h0, "unmapped");
        hold <= 1'b1;
        bus(1'b1, ADDR_CTRL, 32'h31);
        waitf(6, 1'b1, 3, "q_oe_reset");
        hold <= 1'b0;
        waitf(6, 1'b0, 4, "q_oe_cs");
        cs_n <= 1'b0;
        rchk(ADDR_CTRL, 32'h30, "straps");
        base = wr_cnt;
        push(2);
        waitf(1, 1'b1, 3, "empty_release");
        pop({56'h0, base}, "first_word");
        bus(1'b1, ADDR_CTRL, 32'h34);
        waitf(1, 1'b0, 3, "rt_setup");
        waitf(1, 1'b1, 6, "rt_done");
        pop({56'h0, base}, "rt_word");
        bus(1'b1, ADDR_PAE_OFF, 32'h5);
        bus(1'b1, ADDR_PAF_OFF, 32'h1f0);
        load_n <= 1'b0;
        pop(72'h5, "off_ae");
        pop(72'h1f0, "off_af");
        load_n <= 1'b1;
        bus(1'b1, ADDR_CTRL, 32'h39);
        waitf(2, 1'b0, 4, "ft_ready");
        bus(1'b1, ADDR_INT_MASK, 32'h0);
        bus(1'b0, ADDR_INT_STAT, 32'h0);
        push(int'(DEPTH_FT));
        waitf(2, 1'b1, 4, "ft_full");
        waitf(3, 1'b0, 2, "ft_out_ready");
        waitf(7, 1'b1, 2, "ft_full_held");
        waitf(8, 1'b1, 2, "aempty_off");
        rchk(ADDR_STATUS, 32'h02010005, "status_full");
        waitf(0, 1'b0, 2, "hresp_okay");
        waitf(4, 1'b0, 2, "afull");
        waitf(5, 1'b0, 2, "irq_masked");
        bus(1'b1, ADDR_INT_MASK, 32'h1);
        waitf(5, 1'b1, 3, "irq_on");
        rchk(ADDR_INT_STAT, 32'h5, "int_stat");
        waitf(5, 1'b0, 3, "irq_clear");
        @(negedge hclk);
        chk("ft_first", {56'h0, wr_cnt - 16'(DEPTH_FT)}, q_data);
        pop({56'h0, wr_cnt - 16'(DEPTH_FT) + 16'h1}, "ft_word");
        waitf(2, 1'b0, 3, "ready_again");
        // Zero-latency retransmit with asynchronous almost-full
        bus(1'b1, ADDR_CTRL, 32'h1);
        bus(1'b1, ADDR_PAF_OFF, 32'h1fe);
        base = wr_cnt;
        push(2);
        waitf(4, 1'b0, 4, "async_afull");
        bus(1'b1, ADDR_CTRL, 32'h4);
        repeat (2) @(negedge hclk);
        chk("zl_word", {56'h0, base}, q_data);
        waitf(4, 1'b1, 4, "async_afull_clr");
        pop({56'h0, base + 16'h1}, "zl_next");
        // Partial reset keeps offsets and ignores chip select
        cs_n <= 1'b1;
        bus(1'b1, ADDR_CTRL, 32'h2);
        waitf(6, 1'b1, 1, "q_oe_prst");
        waitf(6, 1'b0, 4, "q_oe_prst_end");
        rchk(ADDR_STATUS, 32'ha, "prst_status");
        rchk(ADDR_PAF_OFF, 32'h1fe, "prst_keep");
        summarize();
    end
endmodule
